// file: verilog/civ_pkg.sv
/*
  Constants, register map and carrier types for the interrupt vectoring
  block. Assumes a 32-bit AXI4-Lite register bus and a core pipeline that
  reports instruction boundaries and its special instructions.
*/
// How it works
// - Reset and each source own one vector
// - Source enable and global enable both required
// - Lowest vector wins; reset, then request zero
// - Relocate select moves vectors to boot start
// - Boot fuse moves reset vector to boot
// - Boot lock bits suppress by program region
// - Taking an interrupt clears global enable
// - Handler re-enabling global allows nesting
// - Return instruction sets global enable
// - Hardware clears flag when vectoring
// - Writing one clears flag; zero ignored
// - Flag latched while disabled, served later
// - Flags pending while global off, priority order
// - Level sources request only while present
// - One main instruction after return first
// - Flags register never saved or restored
// - Clear-global blocks even same-cycle request
// - Instruction after set-global runs first
// - Entry at least five cycles, pushes PC
// - Vector jump takes three cycles
// - Multi-cycle instruction completes before entry
// - Wake from sleep adds five cycles
// - Return five cycles, pops three bytes
package civ_pkg;

  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_ENABLE = 8'h04;
  localparam logic [ADDR_W-1:0] REG_FLAG   = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0c;

  // Control register fields
  localparam int CTRL_GIE_BIT = 0;
  localparam int CTRL_REL_BIT = 1;

  // Status register fields
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_HOLD_BIT = 1;
  localparam int STS_PEND_BIT = 2;
  localparam int STS_VEC_LSB  = 8;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Sequence lengths in core clock cycles
  localparam int ENTRY_CYC  = 5;
  localparam int JUMP_CYC   = 3;
  localparam int WAKE_CYC   = 5;
  localparam int RETURN_CYC = 5;
  localparam int RET_POP_BYTES = 3;
  localparam int CNT_W = 4;

  localparam int VEC_STRIDE = 2;

  // Pipeline report, one cycle per event
  typedef struct packed {
    logic done;
    logic is_sei;
    logic is_cli;
    logic is_return_from_interrupt_instr;
    logic sleeping;
  } civ_cpu_evt_t;

  typedef enum {ST_RUN, ST_ENTRY, ST_JUMP, ST_RET} civ_state_t;

endpackage

// file: verilog/civ_vectoring.sv
/*
  Interrupt gathering, priority and vectoring sequencer with its register
  file on AXI4-Lite. Assumes sources give one-cycle event pulses (flag
  type) or levels, and the pipeline stalls while cpu_stall is high.
*/
`timescale 1ns/1ns
module civ_vectoring
  import civ_pkg::*;
#(
  parameter int NSRC     = 8,
  parameter int PC_W     = 16,
  parameter logic [31:0] LEVEL_MASK = 32'h0000_0000
)(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [NSRC-1:0]   src_event,
  input  wire logic [NSRC-1:0]   src_level,
  input  wire civ_cpu_evt_t      cpu_evt,
  input  wire logic [PC_W-1:0]   cpu_pc,
  input  wire logic [PC_W-1:0]   boot_start,
  input  wire logic              reset_vector_boot_fuse,
  input  wire logic              app_boot_lock_bit,
  input  wire logic              boot_section_lock_bit,
  output logic                   cpu_stall,
  output logic                   pc_push,
  output logic                   pc_pop,
  output logic                   vector_load,
  output logic                   handler_start,
  output logic [PC_W-1:0]        vector_pc,
  output logic [PC_W-1:0]        reset_vector,
  output logic                   global_enable
);

  // Refuse sizes that the index and counter widths cannot hold
  if (NSRC < 1 || NSRC > 24 || PC_W < 8 || PC_W > 24)
  begin : g_bad_size
    $error("NSRC must be 1..24 and PC_W 8..24");
  end

  localparam int VEC_W = 8;

  // ==========================================================
  // State
  // ==========================================================
  civ_state_t             state_r, state_nxt;
  logic [CNT_W-1:0]       cnt_r, cnt_nxt;
  logic [NSRC-1:0]        flag_r, flag_nxt;
  logic [NSRC-1:0]        enable_r, enable_nxt;
  logic                   gie_r, gie_nxt;
  logic                   reloc_r, reloc_nxt;
  logic                   hold_r, hold_nxt;
  logic [VEC_W-1:0]       vec_r, vec_nxt;
  logic [PC_W-1:0]        vpc_r, vpc_nxt;
  logic                   entry_first_r;

  // ==========================================================
  // Bus decode
  // ==========================================================
  logic                   aw_got_r, w_got_r, bvalid_r;
  logic [ADDR_W-1:0]      awaddr_r;
  logic [31:0]            wdata_r;
  logic [3:0]             wstrb_r;
  logic [1:0]             bresp_r;
  logic                   rvalid_r;
  logic [31:0]            rdata_r;
  logic [1:0]             rresp_r;

  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire  = s_axi_wvalid & s_axi_wready;
  wire ar_fire = s_axi_arvalid & s_axi_arready;

  wire [ADDR_W-1:0] wa = aw_fire ? s_axi_awaddr : awaddr_r;
  wire [31:0] wd = w_fire ? s_axi_wdata : wdata_r;
  wire [3:0]  ws = w_fire ? s_axi_wstrb : wstrb_r;
  wire aw_have = aw_got_r | aw_fire;
  wire w_have  = w_got_r | w_fire;
  wire wr_go   = aw_have & w_have & ~bvalid_r;

  wire [31:0] wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
  wire [31:0] wbits = wd & wmask;

  wire wr_ctrl = wr_go & (wa == REG_CTRL);
  wire wr_en   = wr_go & (wa == REG_ENABLE);
  wire wr_flag = wr_go & (wa == REG_FLAG);
  wire wr_hit  = (wa == REG_CTRL) | (wa == REG_ENABLE) |
                 (wa == REG_FLAG) | (wa == REG_STATUS);

  wire rd_hit = (s_axi_araddr == REG_CTRL) | (s_axi_araddr == REG_ENABLE) |
                (s_axi_araddr == REG_FLAG) | (s_axi_araddr == REG_STATUS);

  assign s_axi_awready = ~aw_got_r & ~bvalid_r;
  assign s_axi_wready  = ~w_got_r & ~bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // ==========================================================
  // Requests and priority
  // ==========================================================
  logic [NSRC-1:0] lvl_mask;
  logic [NSRC-1:0] raw_req;
  logic [NSRC-1:0] req;
  logic [VEC_W-1:0] win_idx;
  logic            win_any;

  assign lvl_mask = LEVEL_MASK[NSRC-1:0];

  // Level sources bypass the flags and vanish with their condition
  genvar g;
  generate
    for (g = 0; g < NSRC; g++)
    begin : g_req
      assign raw_req[g] = lvl_mask[g] ? src_level[g] : flag_r[g];
      assign req[g] = raw_req[g] & enable_r[g];
    end
  endgenerate

  // Lowest index is lowest vector, so it wins
  always_comb
  begin
    win_idx = '0;
    win_any = 1'b0;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        win_idx = VEC_W'(i);
        win_any = 1'b1;
      end
    end
  end

  // ==========================================================
  // Vector placement
  // ==========================================================
  wire [PC_W-1:0] vec_base = reloc_r ? boot_start : '0;
  wire [PC_W-1:0] win_slot = PC_W'(win_idx) + PC_W'(1);

  // Slot 0 is reset; sources follow at one stride each
  assign vpc_nxt = (state_r == ST_RUN) ?
                   PC_W'(vec_base + win_slot * PC_W'(VEC_STRIDE)) : vpc_r;

  assign reset_vector = reset_vector_boot_fuse ? boot_start : '0;

  // Boot lock: interrupts pointing across a locked boundary wait, still pending, until the lock clears
  wire pc_in_boot = (cpu_pc >= boot_start);
  wire lock_block = (app_boot_lock_bit & ~pc_in_boot & reloc_r) |
                    (boot_section_lock_bit & pc_in_boot & ~reloc_r);

  // ==========================================================
  // Acceptance
  // ==========================================================
  wire boundary = cpu_evt.done | cpu_evt.sleeping;
  wire ret_start = (state_r == ST_RUN) & cpu_evt.done & cpu_evt.is_return_from_interrupt_instr;

  // The old enable counts and the set and clear bits mask as well, so the
  // set-global instruction itself and a same-cycle clear both leave the request waiting
  wire take = (state_r == ST_RUN) & boundary & ~cpu_evt.is_return_from_interrupt_instr &
              gie_r & ~cpu_evt.is_cli & ~cpu_evt.is_sei &
              (~hold_r | cpu_evt.done) & win_any & ~lock_block;

  wire [CNT_W-1:0] entry_len = cpu_evt.sleeping ?
                               CNT_W'(ENTRY_CYC + WAKE_CYC) :
                               CNT_W'(ENTRY_CYC);
  wire cnt_last = (cnt_r == CNT_W'(1));

  // ==========================================================
  // Sequencer
  // ==========================================================
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ST_RUN:
      begin
        if (ret_start)
        begin
          state_nxt = ST_RET;
          cnt_nxt   = CNT_W'(RETURN_CYC);
        end
        else if (take)
        begin
          state_nxt = ST_ENTRY;
          cnt_nxt   = entry_len;
        end
      end
      ST_ENTRY:
      begin
        cnt_nxt = cnt_r - CNT_W'(1);
        if (cnt_last)
        begin
          state_nxt = ST_JUMP;
          cnt_nxt   = CNT_W'(JUMP_CYC);
        end
      end
      ST_JUMP, ST_RET:
      begin
        cnt_nxt = cnt_r - CNT_W'(1);
        if (cnt_last)
          state_nxt = ST_RUN;
      end
      default:
      begin
        state_nxt = ST_RUN;
        cnt_nxt   = '0;
      end
    endcase
  end

  wire ret_done = (state_r == ST_RET) & cnt_last;

  assign vec_nxt = take ? win_idx : vec_r;

  // ==========================================================
  // Global enable and hold-off
  // ==========================================================
  // Later lines win: bus write, set, clear, entry, then return end
  always_comb
  begin
    gie_nxt = gie_r;
    if (wr_ctrl & ws[0])
      gie_nxt = wd[CTRL_GIE_BIT];
    if (cpu_evt.done & cpu_evt.is_sei)
      gie_nxt = 1'b1;
    if (cpu_evt.is_cli)
      gie_nxt = 1'b0;
    if (take)
      gie_nxt = 1'b0;
    if (ret_done)
      gie_nxt = 1'b1;
  end

  // One instruction must retire after return or set-global
  always_comb
  begin
    hold_nxt = hold_r;
    if (cpu_evt.done)
      hold_nxt = 1'b0;
    if (ret_done | (cpu_evt.done & cpu_evt.is_sei))
      hold_nxt = 1'b1;
  end

  assign reloc_nxt = (wr_ctrl & ws[0]) ? wd[CTRL_REL_BIT] : reloc_r;
  assign enable_nxt = wr_en ? (enable_r & ~wmask[NSRC-1:0]) | wbits[NSRC-1:0]
                            : enable_r;

  // ==========================================================
  // Flags
  // ==========================================================
  logic [NSRC-1:0] sw_clr;
  logic [NSRC-1:0] hw_clr;
  assign sw_clr = wr_flag ? wbits[NSRC-1:0] : '0;
  assign hw_clr = take ? (NSRC'(1) << win_idx) : '0;

  // A new event in the clearing cycle survives
  assign flag_nxt = ((flag_r & ~sw_clr & ~hw_clr) | src_event) &
                    ~lvl_mask;

  // ==========================================================
  // Read data
  // ==========================================================
  logic [31:0] ctrl_rd, status_rd, rd_mux;
  always_comb
  begin
    ctrl_rd = '0;
    ctrl_rd[CTRL_GIE_BIT] = gie_r;
    ctrl_rd[CTRL_REL_BIT] = reloc_r;
    status_rd = '0;
    status_rd[STS_BUSY_BIT] = (state_r != ST_RUN);
    status_rd[STS_HOLD_BIT] = hold_r;
    status_rd[STS_PEND_BIT] = win_any;
    status_rd[STS_VEC_LSB +: VEC_W] = vec_r;
    case (s_axi_araddr)
      REG_CTRL:   rd_mux = ctrl_rd;
      REG_ENABLE: rd_mux = 32'(enable_r);
      REG_FLAG:   rd_mux = 32'(raw_req);
      REG_STATUS: rd_mux = status_rd;
      default:    rd_mux = '0;
    endcase
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r  <= ST_RUN;
      cnt_r    <= '0;
      flag_r   <= '0;
      enable_r <= '0;
      gie_r    <= 1'b0;
      reloc_r  <= 1'b0;
      hold_r   <= 1'b0;
      vec_r    <= '0;
      vpc_r    <= '0;
      entry_first_r <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      flag_r   <= flag_nxt;
      enable_r <= enable_nxt;
      gie_r    <= gie_nxt;
      reloc_r  <= reloc_nxt;
      hold_r   <= hold_nxt;
      vec_r    <= vec_nxt;
      vpc_r    <= vpc_nxt;
      entry_first_r <= take;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
      awaddr_r <= '0;
      wdata_r  <= '0;
      wstrb_r  <= '0;
    end
    else
    begin
      if (aw_fire)
        awaddr_r <= s_axi_awaddr;
      if (w_fire)
      begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      aw_got_r <= wr_go ? 1'b0 : aw_have;
      w_got_r  <= wr_go ? 1'b0 : w_have;
      if (wr_go)
      begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end
    else if (ar_fire)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  // ==========================================================
  // Core-facing outputs
  // ==========================================================
  // Flags register is the pipeline's business; nothing is saved here
  assign cpu_stall     = (state_r != ST_RUN);
  assign pc_push       = entry_first_r;
  assign pc_pop        = ret_done;
  assign vector_load   = (state_r == ST_ENTRY) & cnt_last;
  assign handler_start = (state_r == ST_JUMP) & cnt_last;
  assign vector_pc     = vpc_r;
  assign global_enable = gie_r;

endmodule // civ_vectoring

// file: sim/civ_vectoring_asserts.sv
/*
  Port-level checker for civ_vectoring, bound at the foot of this file.
  Assumes only the top module's ports and the package types.
*/
`timescale 1ns/1ns
module civ_vectoring_asserts
  import civ_pkg::*;
#(
  parameter int PC_W = 16
)(
  input wire logic            aclk,
  input wire logic            aresetn,
  input wire civ_cpu_evt_t    cpu_evt,
  input wire logic [PC_W-1:0] boot_start,
  input wire logic            reset_vector_boot_fuse,
  input wire logic            cpu_stall,
  input wire logic            pc_push,
  input wire logic            pc_pop,
  input wire logic            vector_load,
  input wire logic            handler_start,
  input wire logic [PC_W-1:0] reset_vector,
  input wire logic            global_enable
);
  // ==========
  // Entry, return and gating
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  entry_len_a: assert property (
    pc_push && !$past(cpu_evt.sleeping) |-> ##4 vector_load)
    else $error("vector load not four cycles after push");
  stall_len_a: assert property (
    pc_push && !$past(cpu_evt.sleeping) |-> cpu_stall [*8] ##1 !cpu_stall)
    else $error("entry stall not eight cycles");
  jump_len_a: assert property (vector_load |-> ##3 handler_start)
    else $error("handler start not three cycles after load");
  gie_clear_a: assert property (pc_push |-> !global_enable)
    else $error("global enable kept on entry");
  push_gate_a: assert property (
    pc_push |-> $past(global_enable) && $past(cpu_evt.done || cpu_evt.sleeping))
    else $error("entry without enable or completion");
  stall_block_a: assert property (cpu_stall |=> !pc_push)
    else $error("entry started while stalled");
  cli_block_a: assert property (cpu_evt.is_cli |=> !pc_push)
    else $error("entry beside clear-global");
  sei_defer_a: assert property (
    cpu_evt.done && cpu_evt.is_sei |=> !pc_push ##1 (!pc_push || $past(cpu_evt.done)))
    else $error("entry right after set-global");
  ret_seq_a: assert property (
    cpu_evt.done && cpu_evt.is_return_from_interrupt_instr |=> (cpu_stall && !pc_pop) [*4]
    ##1 (cpu_stall && pc_pop) ##1 (global_enable && !cpu_stall))
    else $error("return sequence wrong");
  ret_one_a: assert property (
    pc_pop |=> !pc_push ##1 (!pc_push || $past(cpu_evt.done)))
    else $error("entry before one main instruction");
  rst_vec_a: assert property (
    reset_vector == (reset_vector_boot_fuse ? boot_start : '0))
    else $error("reset vector wrong");
  cover property (pc_push);
  cover property (handler_start ##[1:20] pc_push);
  cover property (pc_pop);
endmodule // civ_vectoring_asserts

bind civ_vectoring civ_vectoring_asserts #(.PC_W(PC_W)) i_chk (
  .aclk, .aresetn, .cpu_evt, .boot_start, .reset_vector_boot_fuse, .cpu_stall,
  .pc_push, .pc_pop, .vector_load, .handler_start, .reset_vector, .global_enable);

// file: sim/civ_core_model.sv
/*
  Behavioural core pipeline facing civ_vectoring: retires one instruction
  a cycle, one in three when slow. Assumes cmd comes from the bench.
*/
`timescale 1ns/1ns
module civ_core_model
  import civ_pkg::*;
#(
  parameter int PC_W = 16
)(
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic            slow,
  input  wire logic [1:0]      cmd,
  input  wire logic            cpu_stall,
  input  wire logic            pc_push,
  input  wire logic            pc_pop,
  input  wire logic            handler_start,
  input  wire logic [PC_W-1:0] vector_pc,
  output civ_cpu_evt_t         cpu_evt,
  output logic [PC_W-1:0]      cpu_pc
);
  // ==========
  // Retirement and return stack
  logic [1:0]      ph_r = 2'd0;
  logic            run_r = 1'b0;
  logic [PC_W-1:0] pc_r = '0;
  logic [PC_W-1:0] stk [$];
  // Slow mode: completion only on the third cycle
  wire logic       done_w = run_r && !cpu_stall && (!slow || ph_r == 2'd2);
  assign cpu_evt = '{done_w, done_w && cmd == 2'd1, done_w && cmd == 2'd2,
                     done_w && cmd == 2'd3, 1'b0};
  assign cpu_pc = pc_r;
  always @(posedge aclk)
  begin
    run_r <= aresetn;
    ph_r <= (!aresetn || ph_r == 2'd2) ? 2'd0 : ph_r + {1'b0, !cpu_stall};
    if (pc_push)
      stk.push_back(pc_r);
    if (!aresetn)
      pc_r <= '0;
    else if (handler_start)
      pc_r <= vector_pc;
    else if (pc_pop && stk.size() > 0)
      pc_r <= stk.pop_back();
    else if (done_w)
      pc_r <= pc_r + 1'b1;
  end
endmodule // civ_core_model

// file: sim/civ_vectoring_tb.sv
/*
  Self-checking bench for civ_vectoring: a table of vectoring cases, some with several sources raised,
  then reset, bus refusals, clear-global and nesting. Needs the core model.
*/
`timescale 1ns/1ns
module civ_vectoring_tb
  import civ_pkg::*;
;
  typedef struct packed {
    logic [3:0] en;
    logic [3:0] ev;
    logic [3:0] lv;
    logic       rel;
    logic       slw;
    logic [3:0] idx;
  } civ_row_t;
  localparam logic [15:0] BOOT = 16'h1000;
  civ_row_t rows [4] = '{'{4'h3, 4'h3, 4'h0, 1'b0, 1'b0, 4'h0},
    '{4'h6, 4'h7, 4'h0, 1'b0, 1'b1, 4'h1}, '{4'h4, 4'h4, 4'h0, 1'b1, 1'b0, 4'h2},
    '{4'h8, 4'h0, 4'h8, 1'b0, 1'b0, 4'h3}};
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, rdq;
  logic [3:0]  s_axi_wstrb = 4'hf, src_event = 4'h0, src_level = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, slow = 1'b0;
  logic        reset_vector_boot_fuse = 1'b0, app_boot_lock_bit = 1'b0;
  logic        boot_section_lock_bit = 1'b0;
  logic [1:0]  cmd = 2'd0, rsp;
  logic [15:0] boot_start = BOOT;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic   cpu_stall, pc_push, pc_pop, vector_load, handler_start, global_enable;
  wire logic [1:0]   s_axi_bresp, s_axi_rresp;
  wire logic [31:0]  s_axi_rdata;
  wire logic [15:0]  cpu_pc, vector_pc, reset_vector;
  wire civ_cpu_evt_t cpu_evt;
  int          fails = 0, cmp_count = 0, pushes = 0, n0;

  always #4 aclk = ~aclk;
  always @(posedge aclk) if (pc_push) pushes <= pushes + 1;

  civ_vectoring #(.NSRC(4), .PC_W(16), .LEVEL_MASK(32'h8)) i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .src_event, .src_level, .cpu_evt,
    .cpu_pc, .boot_start, .reset_vector_boot_fuse, .app_boot_lock_bit,
    .boot_section_lock_bit, .cpu_stall, .pc_push, .pc_pop, .vector_load,
    .handler_start, .vector_pc, .reset_vector, .global_enable);
  civ_core_model #(.PC_W(16)) i_core (.aclk, .aresetn, .slow, .cmd, .cpu_stall,
    .pc_push, .pc_pop, .handler_start, .vector_pc, .cpu_evt, .cpu_pc);

  // ==========
  // Checking and bus tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic give_up;
    fails++;
    $display("unexpected wait: expected an answer, seen none");
    report_and_stop;
  endtask

  // Holds each channel until its own ready, answers until valid; the
  // response ready stays up until the next call sets it once
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid)
      begin
        rsp = s_axi_bresp;
        break;
      end
      if (s_axi_rready && s_axi_rvalid)
      begin
        rsp = s_axi_rresp;
        rdq = s_axi_rdata;
        break;
      end
    end
    if (n == 40) give_up;
  endtask

  task automatic wait_for(input logic pop);
    int n;
    for (n = 0; n < 60; n++)
    begin
      @(posedge aclk);
      if (pop ? pc_pop : handler_start) break;
    end
    if (n == 60) give_up;
  endtask

  task automatic instr(input logic [1:0] c);
    int n;
    cmd <= c;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (cpu_evt.done) break;
    end
    cmd <= 2'd0;
    if (n == 40) give_up;
  endtask

  // ==========
  // Main sequence
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i])
    begin
      slow <= rows[i].slw;
      axi(1'b1, REG_ENABLE, {28'h0, rows[i].en});
      src_event <= rows[i].ev;
      src_level <= rows[i].lv;
      @(posedge aclk);
      src_event <= 4'h0;
      axi(1'b1, REG_CTRL, {30'h0, rows[i].rel, 1'b1});
      wait_for(1'b0);
      check(32'(vector_pc), 32'((rows[i].rel ? BOOT : 16'h0) + 2 * (rows[i].idx + 1)), "vector");
      check(32'(global_enable), 32'h0, "enable in handler");
      axi(1'b1, REG_FLAG, 32'h0);
      axi(1'b0, REG_FLAG, 32'h0);
      check(rdq, 32'((rows[i].ev & ~(4'h1 << rows[i].idx)) | rows[i].lv), "flags");
      axi(1'b1, REG_ENABLE, 32'h0);
      src_level <= 4'h0;
      instr(2'd3);
      wait_for(1'b1);
      @(posedge aclk);
      check(32'(global_enable), 32'h1, "enable after return");
      axi(1'b1, REG_CTRL, 32'h0);
      axi(1'b1, REG_FLAG, 32'hf);
      axi(1'b0, REG_FLAG, 32'h0);
      check(rdq, 32'h0, "flags cleared");
    end
    // Reset in mid-run must clear the enables written just before it
    axi(1'b1, REG_ENABLE, 32'hf);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 16; a += 4)
    begin
      axi(1'b0, 8'(a), 32'h0);
      check(rdq, 32'h0, "reset value");
      check(32'(rsp), 32'(RESP_OKAY), "read response");
    end
    s_axi_wstrb <= 4'h0;
    axi(1'b1, REG_ENABLE, 32'hf);
    s_axi_wstrb <= 4'hf;
    axi(1'b0, REG_ENABLE, 32'h0);
    check(rdq, 32'h0, "strobed-off write");
    axi(1'b1, 8'h10, 32'hf);
    check(32'(rsp), 32'(RESP_SLVERR), "unmapped write");
    axi(1'b0, 8'h10, 32'h0);
    check(32'(rsp), 32'(RESP_SLVERR), "unmapped read");
    check(rdq, 32'h0, "unmapped data");
    check(32'(reset_vector), 32'h0, "reset vector");
    reset_vector_boot_fuse <= 1'b1;
    @(posedge aclk);
    check(32'(reset_vector), 32'(BOOT), "boot reset vector");
    // Level request in the very cycle of clear-global
    n0 = pushes;
    axi(1'b1, REG_ENABLE, 32'h8);
    axi(1'b1, REG_CTRL, 32'h1);
    src_level <= 4'h8;
    instr(2'd2);
    repeat (12) @(posedge aclk);
    check(32'(pushes - n0), 32'h0, "entries after clear");
    check(32'(global_enable), 32'h0, "enable after clear");
    src_level <= 4'h0;
    axi(1'b1, REG_ENABLE, 32'h6);
    src_event <= 4'h6;
    @(posedge aclk);
    src_event <= 4'h0;
    repeat (8) @(posedge aclk);
    check(32'(pushes - n0), 32'h0, "entries while off");
    instr(2'd1);
    wait_for(1'b0);
    check(32'(vector_pc), 32'h4, "first served");
    instr(2'd1);
    wait_for(1'b0);
    check(32'(vector_pc), 32'h6, "nested vector");
    instr(2'd3);
    wait_for(1'b1);
    instr(2'd3);
    wait_for(1'b1);
    check(32'(pushes - n0), 32'h2, "entry count");
    // Vectors in boot while running in app: app lock holds the request off until released
    app_boot_lock_bit <= 1'b1;
    axi(1'b1, REG_CTRL, 32'h3);
    axi(1'b1, REG_ENABLE, 32'h1);
    src_event <= 4'h1;
    @(posedge aclk);
    src_event <= 4'h0;
    repeat (12) @(posedge aclk);
    check(32'(pushes - n0), 32'h2, "entries while locked");
    app_boot_lock_bit <= 1'b0;
    wait_for(1'b0);
    check(32'(vector_pc), 32'(BOOT) + 32'h2, "unlocked vector");
    report_and_stop;
  end
endmodule // civ_vectoring_tb
